// ==== design/csc_defines.svh ====
// Purpose: shared constants of the calibration statistics command block
// Assumes: included by bare name, after csc_pkg is compiled
// Notes:   offsets are byte addresses on the plain register port
`ifndef CSC_DEFINES_SVH
`define CSC_DEFINES_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CSC_REG_CMD    8'h00
`define CSC_REG_PARAM  8'h04
`define CSC_REG_ROI_X  8'h08
`define CSC_REG_ROI_Y  8'h0c
`define CSC_REG_LIMIT  8'h10
`define CSC_REG_STATUS 8'h14
`define CSC_REG_RESULT 8'h18
// ----------------------------------------
// command codes, operation kinds, column selector and last bin index
// ----------------------------------------
`define CSC_CMD_START  16'h8b00
`define CSC_CMD_READ   16'h8b01
`define CSC_OP_CROSS   8'h00
`define CSC_OP_LUMA    8'h01
`define CSC_SEL_COLUMN 8'h01
`define CSC_BIN_LAST   8'h07
// ----------------------------------------
// field positions
// ----------------------------------------
`define CSC_F_KIND     7:0
`define CSC_F_BIN      15:8
`define CSC_F_SEL      23:16
`define CSC_F_THR      15:0
`define CSC_F_ANGLE    31:16
`define CSC_F_STATUS   7:0
`define CSC_F_BUSY     8
`define CSC_F_RUNNING  9
// ----------------------------------------
// parameter limits and reset values
// ----------------------------------------
`define CSC_THR_MIN    16'h0001
`define CSC_THR_MAX    16'h0064
`define CSC_ANG_MIN    16'h0001
`define CSC_ANG_MAX    16'h0007
`define CSC_RST_WORD   32'h0000_0000
`endif

// ==== design/csc_pkg.sv ====
// Purpose: types of the calibration statistics command block
// Assumes: nothing
// Notes:   constants live in csc_defines.svh
package csc_pkg;
	// one pixel of the streamed video output
	typedef struct packed {
		logic        valid; // pixel present this cycle
		logic        sof;   // first pixel of a frame
		logic        eof;   // last pixel of a frame
		logic [15:0] x;     // column
		logic [15:0] y;     // row
		logic [7:0]  luma;  // brightness
	} csc_pixel_t;
	// inclusive pixel span on one axis
	typedef struct packed {
		logic [15:0] hi;
		logic [15:0] lo;
	} csc_span_t;
	// engine sequencing
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_ARM    = 2'b01,
		ST_GATHER = 2'b10,
		ST_ZOOM   = 2'b11
	} csc_state_t;
	// command result codes
	typedef enum logic [7:0] {
		success_status        = 8'h00,
		no_result_error       = 8'h01,
		bad_index_error       = 8'h02,
		engine_occupied_error = 8'h03,
		bad_param_error       = 8'h04
	} csc_status_t;
endpackage

// ==== design/csc_axis_bins.sv ====
// Purpose: place a pixel position into one of eight near-equal bins of a span
// Assumes: span hi not below lo
// Notes:   purely combinational
`timescale 1ns/1ps
module csc_axis_bins (
	// span edges
	input  wire logic [15:0] i_lo,
	input  wire logic [15:0] i_hi,
	// position on this axis
	input  wire logic [15:0] i_pos,
	// bin answer
	output logic      [2:0]  o_bin,
	output logic             o_inside
);
	logic [16:0] ext;  // inclusive extent
	logic [15:0] rel;  // offset from span start
	logic [19:0] prod; // extent times boundary number

	// -------------------------------
	// boundary compare
	// -------------------------------
	// bin k starts at lo + floor(ext*k/8): slices are consecutive, no gaps
	always_comb begin
		ext = {1'b0, i_hi} - {1'b0, i_lo} + 17'h00001;
		rel = i_pos - i_lo;
		prod = 20'h00000;
		o_bin = 3'h0;
		for (int k = 1; k < 8; k++) begin
			prod = {3'h0, ext} * 20'(k);
			if ({1'b0, rel} >= prod[19:3]) begin
				o_bin = o_bin + 3'h1;
			end
		end
		o_inside = (i_pos >= i_lo) && (i_pos <= i_hi);
	end
endmodule

// ==== design/csc_engine.sv ====
// Purpose: start and read commands of a luma statistics engine on video
// Assumes: pixel stream and command port share I_MCLK
// Notes:   one frame per pass; cross search zooms once per frame
//
// Operation
// - start code 0x8b00 begins an operation
// - kind byte, then x/y start/end spans
// - minimum bin 1..smaller extent over 8
// - edge threshold percent 1..100
// - max angle degrees 1..7
// - refuse start while busy or stopped
// - cross search zooms on brightest bin
// - cross centre is never clamped
// - luma pass ignores minimum bin size
// - eight row bands, eight column bands
// - every pixel inside the window adds luma into 24 bits
// - sums held after completion for reads
// - read code 0x8b01 returns latest results
// - kind, bin index, selector 1 columns
// - no result when absent or stale
// - bad index beyond bin seven
// - occupied while running or stopped
// - cross read gives x low, y high
// - kind 0 cross, 1 luma
// - start returns before gathering ends
// - luma read gives 32-bit zero-extended sum
`timescale 1ns/1ps
`include "csc_defines.svh"
module csc_engine (
	// clock and reset
	input  wire logic                I_MCLK,
	input  wire logic                I_RESET,
	// register port
	input  wire logic [7:0]          I_ADDR,
	input  wire logic [31:0]         I_WDATA,
	input  wire logic                I_WR,
	input  wire logic                I_RD,
	output logic      [31:0]         O_RDATA,
	// video side
	input  wire csc_pkg::csc_pixel_t I_PIX,
	input  wire logic                I_VIDEO_RUNNING,
	// status
	output logic                     O_ENGINE_BUSY
);
	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [31:0]            param;      // kind, bin, selector
	csc_pkg::csc_span_t     roi_x;      // requested x span
	csc_pkg::csc_span_t     roi_y;      // requested y span
	logic [31:0]            limit;      // threshold and angle
	logic [15:0]            cmd_last;   // last command code
	csc_pkg::csc_status_t   status;     // last command result
	logic [31:0]            result;     // last read answer
	csc_pkg::csc_state_t    state;      // engine sequence
	logic [7:0]             run_op;     // kind being run
	csc_pkg::csc_span_t     win_x;      // current x window
	csc_pkg::csc_span_t     win_y;      // current y window
	logic [7:0]             min_bin;    // zoom stop size
	logic [7:0][23:0]       acc_row;    // row band sums
	logic [7:0][23:0]       acc_col;    // column band sums
	logic                   valid_luma; // luma sums readable
	logic                   valid_cross;// centre readable
	logic [15:0]            cx;         // recorded centre x
	logic [15:0]            cy;         // recorded centre y

	// ----------------------------------------
	// decoded signals
	// ----------------------------------------
	logic        busy;       // engine not idle
	logic        cmd_wr;     // write to command word
	logic        start_go;   // accepted start
	logic        params_ok;  // start parameters legal
	logic [2:0]  xbin;       // pixel column band
	logic [2:0]  ybin;       // pixel row band
	logic        xin;        // pixel inside x window
	logic        yin;        // pixel inside y window
	logic        take_pix;   // pixel counted this cycle
	logic        gather_end; // frame closes a pass
	logic        zoom_done;  // bins small enough
	logic [15:0] cen_x;      // centre of brightest column
	logic [15:0] cen_y;      // centre of brightest row
	logic [23:0] read_sum;   // selected bin sum
	logic [7:0]  kind;       // operation_kind field
	logic [7:0]  bin_idx;    // bin field

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// inclusive extent of a span
	function automatic logic [16:0] span_ext(input csc_pkg::csc_span_t s);
		span_ext = {1'b0, s.hi} - {1'b0, s.lo} + 17'h00001;
	endfunction

	// width of one of eight bins
	function automatic logic [15:0] bin_width(input csc_pkg::csc_span_t s);
		logic [16:0] e;
		e = span_ext(s);
		bin_width = {2'b00, e[16:3]};
	endfunction

	// index of the largest of eight sums, lowest wins ties
	function automatic logic [2:0] brightest(input logic [7:0][23:0] a);
		logic [23:0] best;
		best = a[0];
		brightest = 3'h0;
		for (int i = 1; i < 8; i++) begin
			if (a[i] > best) begin
				best = a[i];
				brightest = 3'(i);
			end
		end
	endfunction

	// pixel at the middle of bin idx of a span
	function automatic logic [15:0] bin_centre(input csc_pkg::csc_span_t s,
		input logic [2:0] idx);
		logic [19:0] off;
		logic [15:0] w;
		off = {3'h0, span_ext(s)} * {17'h00000, idx};
		w = bin_width(s);
		bin_centre = s.lo + off[18:3] + {1'b0, w[15:1]};
	endfunction

	// half-size window around c; only the pixel-zero edge is guarded
	function automatic csc_pkg::csc_span_t zoom_span(input csc_pkg::csc_span_t s,
		input logic [15:0] c);
		logic [16:0]        e;
		logic [15:0]        q;
		csc_pkg::csc_span_t r; // window being built
		e = span_ext(s);
		q = {1'b0, e[16:2]};
		r.lo = (c >= q) ? c - q : 16'h0000;
		r.hi = r.lo + e[16:1] - 16'h0001;
		zoom_span = r;
	endfunction

	// ----------------------------------------
	// pixel placement
	// ----------------------------------------
	csc_axis_bins u_xbins (
		.i_lo     (win_x.lo),
		.i_hi     (win_x.hi),
		.i_pos    (I_PIX.x),
		.o_bin    (xbin),
		.o_inside (xin)
	);

	csc_axis_bins u_ybins (
		.i_lo     (win_y.lo),
		.i_hi     (win_y.hi),
		.i_pos    (I_PIX.y),
		.o_bin    (ybin),
		.o_inside (yin)
	);

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	// start checks; edge and angle are only range-checked, for a cross start
	always_comb begin
		logic [15:0] wx;
		logic [15:0] wy;
		logic [15:0] lim;
		logic        span_ok;
		logic        cross_ok;
		wx = bin_width(roi_x);
		wy = bin_width(roi_y);
		lim = (wx < wy) ? wx : wy;
		kind = param[`CSC_F_KIND];
		bin_idx = param[`CSC_F_BIN];
		busy = (state != csc_pkg::ST_IDLE);
		cmd_wr = I_WR && (I_ADDR == `CSC_REG_CMD);
		span_ok = (roi_x.hi >= roi_x.lo) && (roi_y.hi >= roi_y.lo);
		cross_ok = (bin_idx != 8'h00) && ({8'h00, bin_idx} <= lim) &&
			(limit[`CSC_F_THR] >= `CSC_THR_MIN) &&
			(limit[`CSC_F_THR] <= `CSC_THR_MAX) &&
			(limit[`CSC_F_ANGLE] >= `CSC_ANG_MIN) &&
			(limit[`CSC_F_ANGLE] <= `CSC_ANG_MAX);
		// luma pass takes any minimum bin value
		params_ok = span_ok && ((kind == `CSC_OP_LUMA) ||
			((kind == `CSC_OP_CROSS) && cross_ok));
		start_go = cmd_wr && (I_WDATA[15:0] == `CSC_CMD_START) &&
			!busy && I_VIDEO_RUNNING && params_ok;
		read_sum = (param[`CSC_F_SEL] == `CSC_SEL_COLUMN) ?
			acc_col[bin_idx[2:0]] : acc_row[bin_idx[2:0]];
	end

	// ----------------------------------------
	// engine datapath decode
	// ----------------------------------------
	always_comb begin
		take_pix = I_PIX.valid && xin && yin &&
			((state == csc_pkg::ST_GATHER) ||
			((state == csc_pkg::ST_ARM) && I_PIX.sof));
		gather_end = (state == csc_pkg::ST_GATHER) && I_PIX.eof && I_VIDEO_RUNNING;
		cen_x = bin_centre(win_x, brightest(acc_col));
		cen_y = bin_centre(win_y, brightest(acc_row));
		zoom_done = (bin_width(win_x) <= {8'h00, min_bin}) &&
			(bin_width(win_y) <= {8'h00, min_bin});
	end

	// ----------------------------------------
	// parameter registers
	// ----------------------------------------
	// the engine keeps its own copies, so these may change mid-run
	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			param <= `CSC_RST_WORD;
			roi_x <= `CSC_RST_WORD;
			roi_y <= `CSC_RST_WORD;
			limit <= `CSC_RST_WORD;
		end else if (I_WR) begin
			unique case (I_ADDR)
				`CSC_REG_PARAM: param <= I_WDATA;
				`CSC_REG_ROI_X: roi_x <= I_WDATA;
				`CSC_REG_ROI_Y: roi_y <= I_WDATA;
				`CSC_REG_LIMIT: limit <= I_WDATA;
				default: ; // other offsets hold nothing writable
			endcase
		end
	end

	// ----------------------------------------
	// command execution
	// ----------------------------------------
	// every command finishes in the cycle it is written
	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			cmd_last <= 16'h0000;
			status <= csc_pkg::success_status;
			result <= `CSC_RST_WORD;
		end else if (cmd_wr) begin
			cmd_last <= I_WDATA[15:0];
			if (I_WDATA[15:0] == `CSC_CMD_START) begin
				// start only arms the engine and returns
				if (busy || !I_VIDEO_RUNNING) begin
					status <= csc_pkg::engine_occupied_error;
				end else if (!params_ok) begin
					status <= csc_pkg::bad_param_error;
				end else begin
					status <= csc_pkg::success_status;
				end
			end else if (I_WDATA[15:0] == `CSC_CMD_READ) begin
				if (busy || !I_VIDEO_RUNNING) begin
					status <= csc_pkg::engine_occupied_error;
				end else if (kind == `CSC_OP_CROSS && valid_cross) begin
					status <= csc_pkg::success_status;
					result <= {cy, cx};
				end else if (kind != `CSC_OP_LUMA || !valid_luma) begin
					status <= csc_pkg::no_result_error;
				end else if (bin_idx > `CSC_BIN_LAST) begin
					status <= csc_pkg::bad_index_error;
				end else begin
					status <= csc_pkg::success_status;
					result <= {8'h00, read_sum};
				end
			end else begin
				// unknown code
				status <= csc_pkg::bad_param_error;
			end
		end
	end

	// ----------------------------------------
	// engine sequence
	// ----------------------------------------
	// losing video aborts the pass; its results stay invalid
	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			state <= csc_pkg::ST_IDLE;
			run_op <= `CSC_OP_CROSS;
			win_x <= `CSC_RST_WORD;
			win_y <= `CSC_RST_WORD;
			min_bin <= 8'h00;
		end else if (start_go) begin
			state <= csc_pkg::ST_ARM;
			run_op <= kind;
			win_x <= roi_x;
			win_y <= roi_y;
			min_bin <= bin_idx;
		end else if (busy && !I_VIDEO_RUNNING) begin
			state <= csc_pkg::ST_IDLE;
		end else begin
			unique case (state)
				csc_pkg::ST_IDLE: ;
				csc_pkg::ST_ARM: begin
					// wait for a whole frame
					if (I_PIX.sof) begin
						state <= csc_pkg::ST_GATHER;
					end
				end
				csc_pkg::ST_GATHER: begin
					// a luma pass is a single frame
					if (I_PIX.eof) begin
						state <= (run_op == `CSC_OP_LUMA) ?
							csc_pkg::ST_IDLE : csc_pkg::ST_ZOOM;
					end
				end
				csc_pkg::ST_ZOOM: begin
					if (zoom_done) begin
						state <= csc_pkg::ST_IDLE;
					end else begin
						// recentre on the brightest bins, half size
						win_x <= zoom_span(win_x, cen_x);
						win_y <= zoom_span(win_y, cen_y);
						state <= csc_pkg::ST_ARM;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// accumulators
	// ----------------------------------------
	// 24 bits hold a full 720x480 band of peak luma without wrap
	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			acc_row <= '0;
			acc_col <= '0;
		end else if (start_go || state == csc_pkg::ST_ZOOM) begin
			acc_row <= '0;
			acc_col <= '0;
		end else if (take_pix) begin
			acc_row[ybin] <= acc_row[ybin] + {16'h0000, I_PIX.luma};
			acc_col[xbin] <= acc_col[xbin] + {16'h0000, I_PIX.luma};
		end
	end

	// ----------------------------------------
	// results
	// ----------------------------------------
	// a start drops both result sets; setting can never meet that clear
	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			valid_luma <= 1'b0;
			valid_cross <= 1'b0;
			cx <= 16'h0000;
			cy <= 16'h0000;
		end else if (start_go) begin
			valid_luma <= 1'b0;
			valid_cross <= 1'b0;
		end else if (gather_end && run_op == `CSC_OP_LUMA) begin
			valid_luma <= 1'b1;
		end else if (state == csc_pkg::ST_ZOOM && zoom_done && I_VIDEO_RUNNING) begin
			valid_cross <= 1'b1;
			cx <= cen_x;
			cy <= cen_y;
		end
	end

	// ----------------------------------------
	// register read port
	// ----------------------------------------
	// data stands only in the cycle after the strobe
	always_ff @(posedge I_MCLK) begin
		if (I_RESET || !I_RD) begin
			O_RDATA <= `CSC_RST_WORD;
		end else begin
			unique case (I_ADDR)
				`CSC_REG_CMD:    O_RDATA <= {16'h0000, cmd_last};
				`CSC_REG_PARAM:  O_RDATA <= param;
				`CSC_REG_ROI_X:  O_RDATA <= roi_x;
				`CSC_REG_ROI_Y:  O_RDATA <= roi_y;
				`CSC_REG_LIMIT:  O_RDATA <= limit;
				`CSC_REG_STATUS: O_RDATA <= {22'h000000, I_VIDEO_RUNNING, busy, status};
				`CSC_REG_RESULT: O_RDATA <= result;
				default:         O_RDATA <= `CSC_RST_WORD;
			endcase
		end
	end

	assign O_ENGINE_BUSY = busy;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_start_cmd;
		cmd_wr && I_WDATA[15:0] == `CSC_CMD_START;
	endsequence
	sequence s_read_cmd;
		cmd_wr && I_WDATA[15:0] == `CSC_CMD_READ;
	endsequence
	sequence s_read_idle;
		s_read_cmd ##0 (!busy && I_VIDEO_RUNNING && kind == `CSC_OP_LUMA);
	endsequence

	property p_start_refused;
		@(posedge I_MCLK) disable iff (I_RESET)
		s_start_cmd ##0 (busy || !I_VIDEO_RUNNING) |=>
			status == csc_pkg::engine_occupied_error;
	endproperty
	a_start_refused: assert property (p_start_refused)
		else $error("start not refused while occupied");

	property p_start_async;
		@(posedge I_MCLK) disable iff (I_RESET)
		s_start_cmd ##0 start_go |=> busy && !valid_luma && !valid_cross &&
			status == csc_pkg::success_status;
	endproperty
	a_start_async: assert property (p_start_async)
		else $error("accepted start did not arm engine");

	property p_acc_clear;
		@(posedge I_MCLK) disable iff (I_RESET)
		start_go |=> acc_row[0] == 24'h000000 && acc_col[7] == 24'h000000;
	endproperty
	a_acc_clear: assert property (p_acc_clear)
		else $error("accumulators not cleared at start");

	property p_read_busy;
		@(posedge I_MCLK) disable iff (I_RESET)
		s_read_cmd ##0 busy |=> status == csc_pkg::engine_occupied_error;
	endproperty
	a_read_busy: assert property (p_read_busy)
		else $error("read during run not occupied");

	property p_read_none;
		@(posedge I_MCLK) disable iff (I_RESET)
		s_read_idle ##0 !valid_luma |=> status == csc_pkg::no_result_error;
	endproperty
	a_read_none: assert property (p_read_none)
		else $error("missing result not reported");

	property p_read_range;
		@(posedge I_MCLK) disable iff (I_RESET)
		s_read_idle ##0 (valid_luma && bin_idx > `CSC_BIN_LAST) |=>
			status == csc_pkg::bad_index_error && $stable(result);
	endproperty
	a_read_range: assert property (p_read_range)
		else $error("bad bin index accepted");

	property p_luma_done;
		@(posedge I_MCLK) disable iff (I_RESET)
		gather_end && run_op == `CSC_OP_LUMA |=> !busy && valid_luma ##1
			(valid_luma || $past(start_go));
	endproperty
	a_luma_done: assert property (p_luma_done)
		else $error("luma sums not kept after pass");

	property p_luma_no_zoom;
		@(posedge I_MCLK) disable iff (I_RESET)
		run_op == `CSC_OP_LUMA && busy |-> state != csc_pkg::ST_ZOOM;
	endproperty
	a_luma_no_zoom: assert property (p_luma_no_zoom)
		else $error("luma pass entered zoom");

	property p_zoom_step;
		@(posedge I_MCLK) disable iff (I_RESET)
		state == csc_pkg::ST_ZOOM && !zoom_done && I_VIDEO_RUNNING |=>
			state == csc_pkg::ST_ARM && acc_row[3] == 24'h000000;
	endproperty
	a_zoom_step: assert property (p_zoom_step)
		else $error("zoom did not start a new frame");

	property p_rdata_once;
		@(posedge I_MCLK) disable iff (I_RESET)
		!I_RD |=> O_RDATA == `CSC_RST_WORD;
	endproperty
	a_rdata_once: assert property (p_rdata_once)
		else $error("read data outside its cycle");
endmodule

// ==== tb/csc_video_src.sv ====
// Purpose: video source that streams frames into the statistics engine
// Assumes: one pixel per clock, W x H frames, short blanking between frames
// Notes:   bright cross at column BX and row BY, dim ramp elsewhere
`timescale 1ns/1ps
module csc_video_src #(
	parameter int W  = 16,
	parameter int H  = 16,
	parameter int BX = 5,
	parameter int BY = 9
) (
	// clock and reset
	input  wire logic           i_clk,
	input  wire logic           i_rst,
	// pixel stream
	output csc_pkg::csc_pixel_t o_pix
);
	logic [15:0] x;   // column counter
	logic [15:0] y;   // row counter
	logic [2:0]  gap; // blanking cycles left
	// raster scan; frames run free so the engine must wait for sof
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			x <= 16'h0000;
			y <= 16'h0000;
			gap <= 3'h4;
		end else if (gap != 3'h0) begin
			gap <= gap - 3'h1;
		end else if (x == 16'(W - 1)) begin
			x <= 16'h0000;
			y <= (y == 16'(H - 1)) ? 16'h0000 : y + 16'h0001;
			if (y == 16'(H - 1)) begin
				gap <= 3'h4;
			end
		end else begin
			x <= x + 16'h0001;
		end
	end
	// pixel fields; luma counts down the gap in blanking so stale data never looks valid
	always_comb begin
		o_pix.valid = (gap == 3'h0);
		o_pix.sof   = o_pix.valid && (x == 16'h0000) && (y == 16'h0000);
		o_pix.eof   = o_pix.valid && (x == 16'(W - 1)) && (y == 16'(H - 1));
		o_pix.x     = x;
		o_pix.y     = y;
		o_pix.luma  = (x == 16'(BX) || y == 16'(BY)) ? 8'hff : 8'h10 + x[7:0];
		if (!o_pix.valid) begin
			o_pix.luma = {5'h00, gap};
		end
	end
endmodule

// ==== tb/csc_engine_test.sv ====
// Purpose: self-checking bench for the statistics command engine
// Assumes: 16 x 16 frames, cross at column 5 and row 9
// Notes:   commands go through the register port, status read back
`timescale 1ns/1ps
`include "csc_defines.svh"
module csc_engine_test;
	logic                I_MCLK = 1'b0;      // 250 MHz clock
	logic                I_RESET;            // synchronous reset
	logic [7:0]          I_ADDR;             // register offset
	logic [31:0]         I_WDATA;            // write data
	logic                I_WR;               // write strobe
	logic                I_RD;               // read strobe
	logic [31:0]         O_RDATA;            // read data
	csc_pkg::csc_pixel_t I_PIX;              // pixel stream
	logic                I_VIDEO_RUNNING;    // video running state
	logic                O_ENGINE_BUSY;      // engine busy
	int                  err_count;          // mismatches
	int                  checks;             // comparisons
	logic [31:0]         d;                  // read word
	logic [31:0]         rs [8];             // expected row sums
	logic [31:0]         cs [8];             // expected column sums
	logic [31:0]         bad [6] = '{32'h0, 32'h0300, 32'h0200, 32'h0200, 32'h0200, 32'h0200};
	logic [31:0]         lim [6] = '{32'h30032, 32'h30032, 32'h30065, 32'h30000,
	                                 32'h80032, 32'h00032};
	always #2 I_MCLK = ~I_MCLK;
	csc_engine u_csc_engine (.I_MCLK(I_MCLK), .I_RESET(I_RESET), .I_ADDR(I_ADDR),
		.I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_PIX(I_PIX),
		.I_VIDEO_RUNNING(I_VIDEO_RUNNING), .O_ENGINE_BUSY(O_ENGINE_BUSY));
	csc_video_src u_csc_video_src (.i_clk(I_MCLK), .i_rst(I_RESET), .o_pix(I_PIX));
	// ------------------------------------------------
	// access tasks
	// ------------------------------------------------
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
			err_count++;
		end
	endtask
	// one write cycle, strobe dropped at the sampling edge
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge I_MCLK);
		I_ADDR <= a;
		I_WDATA <= v;
		I_WR <= 1'b1;
		@(posedge I_MCLK);
		I_WR <= 1'b0;
	endtask
	// data stands only in the cycle after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge I_MCLK);
		I_ADDR <= a;
		I_RD <= 1'b1;
		@(posedge I_MCLK);
		I_RD <= 1'b0;
		#1 v = O_RDATA;
	endtask
	// full command: parameters, code, then status word
	task automatic op(input logic [15:0] c, input logic [31:0] p, input logic [31:0] l,
		output logic [31:0] st);
		wr(`CSC_REG_PARAM, p);
		wr(`CSC_REG_ROI_X, 32'h000f_0000);
		wr(`CSC_REG_ROI_Y, 32'h000f_0000);
		wr(`CSC_REG_LIMIT, l);
		wr(`CSC_REG_CMD, {16'h0000, c});
		rd(`CSC_REG_STATUS, st);
	endtask
	// bounded wait for the engine to go idle
	task automatic wait_idle();
		int n;
		for (n = 0; n < 3000 && O_ENGINE_BUSY !== 1'b0; n++) begin
			@(posedge I_MCLK);
			#1;
		end
		if (O_ENGINE_BUSY !== 1'b0) begin
			$display("[FAIL] %0t engine never idle", $time);
			err_count++;
			end_sim();
		end
	endtask
	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial begin
		I_RESET = 1'b1;
		I_ADDR = 8'h00;
		I_WDATA = 32'h0;
		I_WR = 1'b0;
		I_RD = 1'b0;
		I_VIDEO_RUNNING = 1'b0;
		err_count = 0;
		checks = 0;
		// expected sums: two rows or two columns per bin of the 16 pixel span
		for (int k = 0; k < 8; k++) begin
			rs[k] = 32'h0;
			cs[k] = 32'h0;
			for (int i = 0; i < 16; i++) begin
				for (int j = 2 * k; j < 2 * k + 2; j++) begin
					rs[k] += (i == 5 || j == 9) ? 32'hff : 32'h10 + i;
					cs[k] += (j == 5 || i == 9) ? 32'hff : 32'h10 + j;
				end
			end
		end
		repeat (20) @(posedge I_MCLK);
		I_RESET <= 1'b0;
		rd(`CSC_REG_STATUS, d);
		chk(d, 32'h0);
		rd(8'h40, d);
		chk(d, 32'h0);
		op(`CSC_CMD_START, 32'h1, 32'h30032, d);
		chk(d, 32'h3);
		op(`CSC_CMD_READ, 32'h1, 32'h30032, d);
		chk(d, 32'h3);
		$display("test stopped video done");
		@(posedge I_MCLK);
		I_VIDEO_RUNNING <= 1'b1;
		op(`CSC_CMD_READ, 32'h1, 32'h30032, d);
		chk(d, 32'h201);
		for (int i = 0; i < 6; i++) begin
			op(`CSC_CMD_START, bad[i], lim[i], d);
			chk(d, 32'h204);
		end
		// unknown code is refused, but still kept as the last code
		op(16'h1234, 32'h1, 32'h30032, d);
		chk(d, 32'h204);
		rd(`CSC_REG_CMD, d);
		chk(d, 32'h1234);
		$display("test parameter limits done");
		op(`CSC_CMD_START, 32'h0301, 32'h30032, d);
		chk(d, 32'h300);
		op(`CSC_CMD_START, 32'h1, 32'h30032, d);
		chk(d, 32'h303);
		op(`CSC_CMD_READ, 32'h1, 32'h30032, d);
		chk(d, 32'h303);
		wait_idle();
		for (int k = 0; k < 8; k++) begin
			op(`CSC_CMD_READ, {16'h0002, k[7:0], 8'h01}, 32'h0, d);
			chk(d, 32'h200);
			rd(`CSC_REG_RESULT, d);
			chk(d, rs[k]);
			op(`CSC_CMD_READ, {16'h0001, k[7:0], 8'h01}, 32'h0, d);
			chk(d, 32'h200);
			rd(`CSC_REG_RESULT, d);
			chk(d, cs[k]);
		end
		op(`CSC_CMD_READ, 32'h0801, 32'h0, d);
		chk(d, 32'h202);
		op(`CSC_CMD_READ, 32'h0, 32'h0, d);
		chk(d, 32'h201);
		$display("test luma bins done");
		op(`CSC_CMD_START, 32'h0100, 32'h30032, d);
		chk(d, 32'h300);
		wait_idle();
		op(`CSC_CMD_READ, 32'h0, 32'h0, d);
		chk(d, 32'h200);
		rd(`CSC_REG_RESULT, d);
		chk(d, {16'd9, 16'd5});
		op(`CSC_CMD_READ, 32'h1, 32'h0, d);
		chk(d, 32'h201);
		$display("test cross search done");
		// video lost mid-pass: engine aborts and leaves no result
		op(`CSC_CMD_START, 32'h1, 32'h30032, d);
		chk(d, 32'h300);
		@(posedge I_MCLK);
		I_VIDEO_RUNNING <= 1'b0;
		wait_idle();
		@(posedge I_MCLK);
		I_VIDEO_RUNNING <= 1'b1;
		op(`CSC_CMD_READ, 32'h1, 32'h0, d);
		chk(d, 32'h201);
		op(`CSC_CMD_READ, 32'h0, 32'h0, d);
		chk(d, 32'h201);
		$display("test video loss done");
		end_sim();
	end
endmodule
